// [hdl/tpw_top.sv]
// Sixteen-bit timer pair with PWM and reset-synchronous three-phase PWM
`timescale 1ns/1ps
`include "tpw_params.svh"

// ==========================================================
// How it works
// RULE1 - Each channel drives up to three PWM pins
// RULE2 - Synchronised channels give six PWM outputs
// RULE3 - Register A sets period when PWM used
// RULE4 - Count clock: oscillator, divided clock, external pin
// RULE5 - Up-counter, period is m plus one
// RULE6 - Active m minus n, inactive n plus one
// RULE7 - Writing start bit one begins counting
// RULE8 - Stop-select one: clearing start halts, pins hold
// RULE9 - Stop-select zero: halt at period match
// RULE10 - Requests on A to D matches, overflow
// RULE11 - B, C, D pins port or pulse
// RULE12 - Active and initial level per pin
// RULE13 - Interrupt pin forces PWM outputs off
// RULE14 - Duty above period never goes active
// RULE15 - Reset-sync: three normal, three counter phases
// RULE16 - Reset-sync: only counter zero increments
// RULE17 - Reset-sync: A0 period, B0 A1 B1 duties
// RULE18 - Reset-sync phase to pin mapping
// RULE19 - Reset-sync: C0 toggles each period
// RULE20 - Reset-sync stop returns pins to initial
// RULE21 - Reset-sync requests from counter zero compares
// RULE22 - Reset-sync levels chosen per phase group
// RULE23 - Active on duty match, inactive at period

module tpw_top (
	// Clock and reset
	input  wire logic               REF_CLK,
	input  wire logic               RESET,
	// Register port
	input  wire tpw_pkg::tpw_bus_s  BUS,
	output logic [15:0]             RDATA,
	// Timer pins
	input  wire logic [7:0]         PIN_IN,
	output tpw_pkg::tpw_pin_s       PIN,
	// External interrupt pin, low forces cutoff
	input  wire logic               CUTOFF_IN,
	// High-speed oscillator and enables
	input  wire logic               HOCO_IN,
	input  wire logic               OSC_OPTION,
	input  wire logic               PERIPH_EN,
	// Interrupt requests, one-cycle pulses
	output tpw_pkg::tpw_irq_s       IRQ
);
	import tpw_pkg::*;

	// ==========================================================
	// Register file
	logic [1:0]  start_ff;
	logic [1:0]  stopsel_ff;
	logic [7:0]  mode_ff;
	logic [7:0]  pinfn_ff;
	logic [7:0]  actlvl_ff;
	logic [7:0]  initlvl_ff;
	logic [1:0]  fcr_ff;
	logic [7:0]  portout_ff;
	logic [7:0]  portoe_ff;
	logic [15:0] gr_ff [2][4];
	logic [15:0] cnt_ff [2];

	wire logic   wr_start   = BUS.wr && BUS.addr == `TPW_OFF_START;
	wire logic   wr_mode    = BUS.wr && BUS.addr == `TPW_OFF_MODE;
	wire logic   wr_pinfn   = BUS.wr && BUS.addr == `TPW_OFF_PINFN;
	wire logic   wr_act     = BUS.wr && BUS.addr == `TPW_OFF_ACTLVL;
	wire logic   wr_init    = BUS.wr && BUS.addr == `TPW_OFF_INITLVL;
	wire logic   wr_fcr     = BUS.wr && BUS.addr == `TPW_OFF_FCR;
	wire logic   wr_pout    = BUS.wr && BUS.addr == `TPW_OFF_PORTOUT;
	wire logic   wr_poe     = BUS.wr && BUS.addr == `TPW_OFF_PORTOE;
	wire logic   wr_gr      = BUS.wr && BUS.addr[7:3] == 5'(`TPW_OFF_GR_BASE >> 3);
	wire logic   wr_cnt0    = BUS.wr && BUS.addr == `TPW_OFF_CNT0;
	wire logic   wr_cnt1    = BUS.wr && BUS.addr == `TPW_OFF_CNT1;

	wire logic   sync_mode  = mode_ff[`TPW_MODE_SYNC];
	wire logic   rsync      = mode_ff[`TPW_MODE_RSYNC];
	wire logic   cut_en     = mode_ff[`TPW_MODE_CUTEN];
	wire tpw_clk_e clk_sel  = tpw_clk_e'(mode_ff[`TPW_MODE_CLK +: 3]);
	wire logic [1:0] edge_sel = mode_ff[`TPW_MODE_EDGE +: 2];

	// ==========================================================
	// Input synchronisers: pins, cutoff, oscillator
	logic [9:0]  in_s1_ff;
	logic [9:0]  in_s2_ff;
	logic [1:0]  edge_d_ff;
	wire logic [9:0] in_raw  = {HOCO_IN, CUTOFF_IN, PIN_IN};
	wire logic   ext_s       = in_s2_ff[`TPW_EXTCLK_PIN];
	wire logic   hoco_s      = in_s2_ff[9];
	wire logic   cut         = cut_en && !in_s2_ff[8]; // RULE13

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			in_s1_ff  <= '0;
			in_s2_ff  <= '0;
			edge_d_ff <= '0;
		end else begin
			in_s1_ff  <= in_raw;
			in_s2_ff  <= in_s1_ff;
			edge_d_ff <= {hoco_s, ext_s};
		end
	end

	// ==========================================================
	// Count clock selection
	logic [4:0]  div_ff;
	wire logic   ext_rise  = ext_s && !edge_d_ff[0];
	wire logic   ext_fall  = !ext_s && edge_d_ff[0];
	wire logic   ext_tick  = (edge_sel == 2'b00) ? ext_rise :
	                         (edge_sel == 2'b01) ? ext_fall : (ext_rise || ext_fall);
	// Oscillator counts only when the option strap allows it
	wire logic   hoco_tick = OSC_OPTION && hoco_s && !edge_d_ff[1];
	logic        src_tick;

	always_comb begin // RULE4
		case (clk_sel)
			TPW_CLK_FCLK:  src_tick = 1'b1;
			TPW_CLK_DIV2:  src_tick = div_ff[0];
			TPW_CLK_DIV4:  src_tick = &div_ff[1:0];
			TPW_CLK_DIV8:  src_tick = &div_ff[2:0];
			TPW_CLK_DIV32: src_tick = &div_ff;
			TPW_CLK_HOCO:  src_tick = hoco_tick;
			TPW_CLK_EXT:   src_tick = ext_tick;
			default:       src_tick = 1'b0;
		endcase
	end

	wire logic   tick = PERIPH_EN && src_tick;

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + 5'h01;
		end
	end

	// ==========================================================
	// Channel run control and compares
	logic [1:0]  run_d_ff;
	wire logic [1:0] run;
	wire logic [1:0] cnt_tick;
	wire logic [1:0] cmp_tick;
	wire logic [15:0] cmp_cnt [2];
	wire logic [3:0] hit [2];
	wire logic [1:0] pm;
	wire logic [1:0] ovf;
	wire logic [1:0] start_rise;

	// Channel one follows channel zero when synchronised; idle in reset-sync
	assign run[0]      = start_ff[0]; // RULE7
	assign run[1]      = rsync ? 1'b0 : (sync_mode ? start_ff[0] : start_ff[1]); // RULE16 RULE2
	assign cnt_tick    = run & {2{tick}};
	// In reset-sync the channel one registers compare against counter zero
	assign cmp_tick[0] = cnt_tick[0];
	assign cmp_tick[1] = rsync ? cnt_tick[0] : cnt_tick[1]; // RULE21
	assign cmp_cnt[0]  = cnt_ff[0];
	assign cmp_cnt[1]  = rsync ? cnt_ff[0] : cnt_ff[1];
	assign start_rise  = run & ~run_d_ff;

	for (genvar c = 0; c < 2; c++) begin : g_cmp
		for (genvar j = 0; j < 4; j++) begin : g_reg
			// Counter passes the period only after a counter or period write, so otherwise a larger duty never hits
			assign hit[c][j] = cmp_tick[c] && cmp_cnt[c] == gr_ff[c][j]; // RULE10 RULE14
		end
		assign ovf[c] = cnt_tick[c] && cnt_ff[c] == `TPW_CNT_MAX && !pm[c];
	end
	assign pm[0] = hit[0][0]; // RULE3
	assign pm[1] = sync_mode ? hit[0][0] : hit[1][0];

	// ==========================================================
	// Counters and start bits
	for (genvar c = 0; c < 2; c++) begin : g_cnt
		wire logic wr_cnt = (c == 0) ? (wr_cnt0 || (sync_mode && wr_cnt1)) :
		                               (wr_cnt1 || (sync_mode && wr_cnt0));
		wire logic [15:0] nxt_cnt = wr_cnt ? BUS.wdata :
		                            !cnt_tick[c] ? cnt_ff[c] :
		                            pm[c] ? 16'h0000 : cnt_ff[c] + 16'h0001; // RULE5
		always_ff @(posedge REF_CLK) begin
			if (RESET) begin
				cnt_ff[c] <= '0;
			end else begin
				cnt_ff[c] <= nxt_cnt;
			end
		end
	end

	// Auto stop at the period match when stop-select is zero
	wire logic [1:0] auto_stop = ~stopsel_ff & pm & cnt_tick; // RULE9 RULE20
	wire logic [1:0] nxt_start = wr_start ? BUS.wdata[`TPW_START_LSB +: 2] :
	                             (start_ff & ~auto_stop); // RULE8

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			start_ff   <= '0;
			stopsel_ff <= '0;
			run_d_ff   <= '0;
			mode_ff    <= `TPW_RST_BYTE;
			pinfn_ff   <= `TPW_RST_BYTE;
			actlvl_ff  <= `TPW_RST_BYTE;
			initlvl_ff <= `TPW_RST_BYTE;
			fcr_ff     <= '0;
			portout_ff <= `TPW_RST_BYTE;
			portoe_ff  <= `TPW_RST_BYTE;
		end else begin
			start_ff   <= nxt_start;
			run_d_ff   <= run;
			if (wr_start)
				stopsel_ff <= BUS.wdata[`TPW_STOPSEL_LSB +: 2];
			if (wr_mode)
				mode_ff    <= BUS.wdata[7:0];
			if (wr_pinfn)
				pinfn_ff   <= BUS.wdata[7:0];
			if (wr_act)
				actlvl_ff  <= BUS.wdata[7:0];
			if (wr_init)
				initlvl_ff <= BUS.wdata[7:0];
			if (wr_fcr)
				fcr_ff     <= BUS.wdata[1:0];
			if (wr_pout)
				portout_ff <= BUS.wdata[7:0];
			if (wr_poe)
				portoe_ff  <= BUS.wdata[7:0];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			gr_ff <= '{default: `TPW_RST_GR};
		end else if (wr_gr) begin
			gr_ff[BUS.addr[2]][BUS.addr[1:0]] <= BUS.wdata;
		end
	end

	// ==========================================================
	// Plain PWM pin levels
	logic [7:0]  lvl_ff;

	for (genvar p = 0; p < 8; p++) begin : g_pwm
		localparam int C = p / 4;
		localparam int J = p % 4;
		// Period match wins, so n equal to m stays inactive
		wire logic nxt_lvl = start_rise[C] ? initlvl_ff[p] : // RULE12
		                     pm[C] && cnt_tick[C] ? !actlvl_ff[p] : // RULE23
		                     (J != 0 && hit[C][J]) ? actlvl_ff[p] : lvl_ff[p]; // RULE6
		always_ff @(posedge REF_CLK) begin
			if (RESET) begin
				lvl_ff[p] <= 1'b0;
			end else begin
				lvl_ff[p] <= nxt_lvl;
			end
		end
	end

	// ==========================================================
	// Reset-synchronous three-phase levels
	logic [2:0]  ph_ff;
	logic        tgl_ff;
	wire logic [2:0] ph_hit = {hit[1][1], hit[1][0], hit[0][1]}; // RULE17
	wire logic   ols_n      = fcr_ff[`TPW_FCR_OLS_N]; // RULE22
	wire logic   ols_c      = fcr_ff[`TPW_FCR_OLS_C];

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ph_ff  <= '0;
			tgl_ff <= 1'b0;
		end else if (start_rise[0]) begin
			ph_ff  <= '0;
			tgl_ff <= initlvl_ff[`TPW_TOGGLE_PIN];
		end else if (pm[0] && cnt_tick[0]) begin
			ph_ff  <= '0;
			tgl_ff <= !tgl_ff; // RULE19
		end else begin
			ph_ff  <= ph_ff | ph_hit;
		end
	end

	// Start cycle still holds the last run's phase state, so show initial levels there
	wire logic       rs_run = run[0] && !start_rise[0];
	// Level select zero: initial high, active low
	wire logic [2:0] nrm = rs_run ? ({3{ols_n}} ~^ ph_ff) : {3{!ols_n}}; // RULE15
	wire logic [2:0] cph = rs_run ? ({3{ols_c}} ^ ph_ff) : {3{!ols_c}}; // RULE20
	// Phase one B0/D0, phase two A1/C1, phase three B1/D1
	wire logic [7:0] rs_lvl = {cph[2], cph[1], nrm[2], nrm[1], cph[0],
	                           (rs_run ? tgl_ff : initlvl_ff[`TPW_TOGGLE_PIN]), nrm[0], 1'b0}; // RULE18

	// ==========================================================
	// Pin multiplexing and cutoff
	wire logic [7:0] pwm_sel  = rsync ? `TPW_RSYNC_PINS : (pinfn_ff & `TPW_PWM_PINS); // RULE11 RULE1
	wire logic [7:0] pwm_lvl  = rsync ? rs_lvl : lvl_ff;
	wire logic       ext_pin  = clk_sel == TPW_CLK_EXT;
	wire logic [7:0] nxt_out  = (pwm_sel & pwm_lvl) | (~pwm_sel & portout_ff);
	// Cutoff floats the pulse outputs; port pins keep their drive
	wire logic [7:0] nxt_oe   = ((pwm_sel & {8{!cut}}) | (~pwm_sel & portoe_ff)) &
	                            ~{7'h00, ext_pin}; // RULE13
	wire tpw_irq_s   nxt_irq  = '{ovf1: ovf[1], match1: hit[1], ovf0: ovf[0], match0: hit[0]}; // RULE10

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			PIN <= '0;
			IRQ <= '0;
		end else begin
			PIN <= '{out: nxt_out, oe: nxt_oe};
			IRQ <= nxt_irq;
		end
	end

	// ==========================================================
	// Read port
	wire logic [15:0] rd_mux =
		(BUS.addr == `TPW_OFF_START)   ? {12'h000, stopsel_ff, start_ff} :
		(BUS.addr == `TPW_OFF_MODE)    ? {8'h00, mode_ff} :
		(BUS.addr == `TPW_OFF_PINFN)   ? {8'h00, pinfn_ff} :
		(BUS.addr == `TPW_OFF_ACTLVL)  ? {8'h00, actlvl_ff} :
		(BUS.addr == `TPW_OFF_INITLVL) ? {8'h00, initlvl_ff} :
		(BUS.addr == `TPW_OFF_FCR)     ? {14'h0000, fcr_ff} :
		(BUS.addr == `TPW_OFF_PORTOUT) ? {8'h00, portout_ff} :
		(BUS.addr == `TPW_OFF_PORTOE)  ? {8'h00, portoe_ff} :
		(BUS.addr[7:3] == 5'(`TPW_OFF_GR_BASE >> 3)) ? gr_ff[BUS.addr[2]][BUS.addr[1:0]] :
		(BUS.addr == `TPW_OFF_CNT0)    ? cnt_ff[0] :
		(BUS.addr == `TPW_OFF_CNT1)    ? cnt_ff[1] :
		(BUS.addr == `TPW_OFF_PININ)   ? {8'h00, in_s2_ff[7:0]} :
		(BUS.addr == `TPW_OFF_STATUS)  ? {13'h0000, cut, run} : 16'h0000;

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			RDATA <= '0;
		end else begin
			RDATA <= BUS.rd ? rd_mux : 16'h0000;
		end
	end

endmodule

// [hdl/tpw_params.svh]
// Register offsets, field positions, reset values and timer constants
`ifndef TPW_PARAMS_SVH
`define TPW_PARAMS_SVH

// ==========================================================
// Register offsets (word index on the register port)
`define TPW_OFF_START   8'h00
`define TPW_OFF_MODE    8'h01
`define TPW_OFF_PINFN   8'h02
`define TPW_OFF_ACTLVL  8'h03
`define TPW_OFF_INITLVL 8'h04
`define TPW_OFF_FCR     8'h05
`define TPW_OFF_PORTOUT 8'h06
`define TPW_OFF_PORTOE  8'h07
`define TPW_OFF_GR_BASE 8'h08
`define TPW_OFF_CNT0    8'h10
`define TPW_OFF_CNT1    8'h11
`define TPW_OFF_PININ   8'h12
`define TPW_OFF_STATUS  8'h13

// ==========================================================
// Field positions
`define TPW_START_LSB   0
`define TPW_STOPSEL_LSB 2
`define TPW_MODE_SYNC   0
`define TPW_MODE_RSYNC  1
`define TPW_MODE_CUTEN  2
`define TPW_MODE_CLK    3
`define TPW_MODE_EDGE   6
`define TPW_FCR_OLS_N   0
`define TPW_FCR_OLS_C   1

// ==========================================================
// Reset values and constants
`define TPW_RST_GR      16'hffff
`define TPW_RST_BYTE    8'h00
`define TPW_CNT_MAX     16'hffff
`define TPW_PWM_PINS    8'hee
`define TPW_RSYNC_PINS  8'hfe
`define TPW_EXTCLK_PIN  0
`define TPW_TOGGLE_PIN  2

`endif

// [hdl/tpw_pkg.sv]
// Types shared by the PWM timer pair
package tpw_pkg;

	typedef enum logic [2:0] {
		TPW_CLK_FCLK   = 3'b000,
		TPW_CLK_DIV2   = 3'b001,
		TPW_CLK_DIV4   = 3'b010,
		TPW_CLK_DIV8   = 3'b011,
		TPW_CLK_DIV32  = 3'b100,
		TPW_CLK_HOCO   = 3'b101,
		TPW_CLK_EXT    = 3'b110
	} tpw_clk_e;

	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} tpw_bus_s;

	// Pin order: A0 B0 C0 D0 A1 B1 C1 D1 from bit 0 up
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} tpw_pin_s;

	typedef struct packed {
		logic       ovf1;
		logic [3:0] match1;
		logic       ovf0;
		logic [3:0] match0;
	} tpw_irq_s;

endpackage

// [tb/tpw_load.sv]
// Load model hanging on the timer pins
`timescale 1ns/1ps
module tpw_load (
	// Pins from the timer
	input  wire tpw_pkg::tpw_pin_s pin,
	input  wire logic              ext_clk,
	// Levels seen on the board
	output logic [7:0]             pin_in
);
	import tpw_pkg::*;
	// Pull-ups, so a released pin never shows its last level; A0 carries the count clock
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_in[i] = pin.oe[i] ? pin.out[i] : (i == 0 ? ext_clk : 1'b1);
		end
	end
endmodule

// [tb/tpw_top_monitor.sv]
// Port checker for the PWM timer pair
`timescale 1ns/1ps
module tpw_monitor (
	// Clock and reset
	input wire logic              REF_CLK,
	input wire logic              RESET,
	// Register port
	input wire tpw_pkg::tpw_bus_s BUS,
	input wire logic [15:0]       RDATA,
	// Pins and sources
	input wire logic [7:0]        PIN_IN,
	input wire tpw_pkg::tpw_pin_s PIN,
	input wire logic              CUTOFF_IN,
	input wire logic              HOCO_IN,
	input wire logic              OSC_OPTION,
	input wire logic              PERIPH_EN,
	// Requests
	input wire tpw_pkg::tpw_irq_s IRQ
);
	import tpw_pkg::*;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	// =========
	// Shadow of control registers, snooped off the bus
	logic [7:0] start_ff, mode_ff, fn_ff, poe_ff, pout_ff;
	wire        wr_start = BUS.wr && BUS.addr == 8'h00;
	wire [2:0]  a1_cfg   = {mode_ff[1], poe_ff[4], pout_ff[4]};
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			{start_ff, mode_ff, fn_ff, poe_ff, pout_ff} <= '0;
		end else if (BUS.wr) begin
			case (BUS.addr)
				8'h00: start_ff <= BUS.wdata[7:0];
				8'h01: mode_ff <= BUS.wdata[7:0];
				8'h02: fn_ff <= BUS.wdata[7:0];
				8'h06: pout_ff <= BUS.wdata[7:0];
				8'h07: poe_ff <= BUS.wdata[7:0];
				default: ;
			endcase
		end
	end
	// =========
	// Properties
	sequence s_auto_stop;
		IRQ.match0[0] && !start_ff[2] && !wr_start;
	endsequence
	// Pipeline may still land one match after the stop write
	sequence s_hold_stop;
		wr_start && BUS.wdata[2] && !BUS.wdata[0] && !mode_ff[1] ##1 !wr_start [*4];
	endsequence
	property p_reset_quiet;
		disable iff (1'b0) RESET |=> PIN.oe == 8'h00 && IRQ == '0;
	endproperty
	property p_rdata_idle;
		!$past(BUS.rd) |-> RDATA == 16'h0000;
	endproperty
	property p_auto_stop;
		s_auto_stop |=> (IRQ.match0 == 4'h0) until wr_start;
	endproperty
	property p_stop_hold;
		s_hold_stop |-> $stable(PIN.out & fn_ff);
	endproperty
	property p_cutoff;
		(mode_ff[2] && !CUTOFF_IN) [*6] |-> (PIN.oe & fn_ff & 8'hee) == 8'h00;
	endproperty
	property p_toggle;
		mode_ff[1] && start_ff[2] && IRQ.match0[0] |=> $changed(PIN.out[2]);
	endproperty
	property p_periph_off;
		!PERIPH_EN [*4] |-> IRQ == '0;
	endproperty
	property p_a1_port;
		$stable(a1_cfg) && $past(a1_cfg, 2) == a1_cfg && !a1_cfg[2]
			|-> {PIN.oe[4], PIN.out[4] & PIN.oe[4]} == {a1_cfg[1], &a1_cfg[1:0]};
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs live after reset");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
	a_auto_stop: assert property (p_auto_stop) else $error("count ran past stop");
	a_stop_hold: assert property (p_stop_hold) else $error("pins moved after stop");
	a_cutoff: assert property (p_cutoff) else $error("pulse pin driven in cutoff");
	a_toggle: assert property (p_toggle) else $error("period pin did not toggle");
	a_periph_off: assert property (p_periph_off) else $error("request while disabled");
	a_a1_port: assert property (p_a1_port) else $error("A1 not a plain port");
endmodule
bind tpw_top tpw_monitor u_mon (
	.REF_CLK(REF_CLK), .RESET(RESET), .BUS(BUS), .RDATA(RDATA), .PIN_IN(PIN_IN), .PIN(PIN),
	.CUTOFF_IN(CUTOFF_IN), .HOCO_IN(HOCO_IN), .OSC_OPTION(OSC_OPTION), .PERIPH_EN(PERIPH_EN), .IRQ(IRQ)
);

// [tb/tb_tpw_top.sv]
// Self-checking bench for the PWM timer pair
`timescale 1ns/1ps
module tb_tpw_top;
	import tpw_pkg::*;
	logic        clk = 0, rst = 1, cut_n = 1, hoco = 0, en = 1, slow_en = 0, rd_q = 0, t_ok = 0, pc = 0, act;
	logic [7:0]  pin_in;
	logic [15:0] rdata, pd, rq[$];
	logic [16:0] iq[$];
	tpw_bus_s    bus = '0;
	tpw_pin_s    pin;
	tpw_irq_s    irq;
	int          fail_count = 0, total_checks = 0, seed = 83, cyc = 0, t_a = 0, m, n;
	int          dv[8] = '{1, 2, 4, 8, 32, 8, 8, 4};
	tpw_top dut (
		.REF_CLK(clk), .RESET(rst), .BUS(bus), .RDATA(rdata), .PIN_IN(pin_in), .PIN(pin),
		.CUTOFF_IN(cut_n), .HOCO_IN(hoco), .OSC_OPTION(1'b1), .PERIPH_EN(en), .IRQ(irq)
	);
	tpw_load u_load (.pin(pin), .ext_clk(hoco & slow_en), .pin_in(pin_in));
	initial forever #2.5 clk = ~clk;
	// Slow source: one rising edge every 8 clocks
	always begin
		repeat (4) @(posedge clk);
		hoco <= ~hoco;
	end
	// =========
	// Tasks
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Idle cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		rq.push_back(e);
		bus <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask
	task automatic test_done;
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// =========
	// Result watcher: read data and match spacing from the last period match
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rd_q <= bus.rd;
		if (rd_q)
			chk({1'b0, rdata}, {1'b0, rq.pop_front()});
		// Pin level lands one clock after the request pulse
		if (pc)
			chk({pin.out[1], pd}, iq.pop_front());
		pc <= t_ok && irq.match0[1:0] != 2'b00 && iq.size() > 0;
		pd <= 16'(cyc - t_a);
		if (irq.match0[0]) begin
			t_a <= cyc;
			t_ok <= 1'b1;
		end else if (bus.wr && bus.addr == 8'h10) begin
			t_ok <= 1'b0;
		end
	end
	initial begin
		#200000;
		fail_count++;
		test_done();
	end
	// =========
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 16; i++)
			rd(8'(i), i < 8 ? 16'h0000 : 16'hffff);
		rd(8'h1f, 16'h0000);
		wr(8'h1f, 16'h5a5a);
		rd(8'h1f, 16'h0000);
		wr(8'h07, 16'h0010);
		wr(8'h06, 16'h0010);
		wr(8'h02, 16'h0002);
		for (int i = 0; i < 8; i++) begin
			m = 3 + $unsigned($random(seed)) % 4;
			n = i == 2 ? m + 1 : $unsigned($random(seed)) % m;
			act = 1'($random(seed));
			slow_en <= i > 5;
			wr(8'h01, {8'h00, i == 7 ? 2'd3 : 2'd0, i > 6 ? 3'd6 : 3'(i), 3'd0});
			wr(8'h08, 16'(m));
			wr(8'h09, 16'(n));
			wr(8'h03, {14'h0, act, 1'b0});
			wr(8'h04, {14'h0, ~act, 1'b0});
			repeat (2) begin
				if (n < m)
					iq.push_back({act, 16'((n + 1) * dv[i])});
				iq.push_back({~act, 16'((m + 1) * dv[i])});
			end
			// Counter restarts from zero so a shorter period is never overrun
			wr(8'h10, 16'h0000);
			wr(8'h00, 16'h0005);
			for (int w = 0; w < 1500 && iq.size() > 0; w++)
				@(posedge clk);
			chk(17'(iq.size()), 17'h0);
			wr(8'h00, 16'h0004);
		end
		wr(8'h01, 16'h0004);
		wr(8'h00, 16'h0005);
		cut_n <= 1'b0;
		repeat (8) @(posedge clk);
		rd(8'h13, 16'h0005);
		en <= 1'b0;
		repeat (6) @(posedge clk);
		en <= 1'b1;
		cut_n <= 1'b1;
		wr(8'h00, 16'h0004);
		wr(8'h01, 16'h0001);
		wr(8'h10, 16'h0003);
		rd(8'h11, 16'h0003);
		slow_en <= 1'b0;
		wr(8'h02, 16'h00fe);
		wr(8'h04, 16'h0004);
		wr(8'h01, 16'h0002);
		wr(8'h00, 16'h0007);
		repeat (60) @(posedge clk);
		rd(8'h13, 16'h0001);
		rd(8'h11, 16'h0003);
		wr(8'h00, 16'h0001);
		repeat (40) @(posedge clk);
		rd(8'h13, 16'h0000);
		rd(8'h12, 16'h00fe);
		test_done();
	end
endmodule
